// [design/spc_map.vh]
// register offsets, field positions, reset values and wake counts of the sleep clock power block
// What this block does
// - divide clock by 32..256 for codes 0101..1000
// - sleep mode 110 with crystal enters standby
// - standby wakes six clock cycles after event
// - gate bit set stops that peripheral's clock
// - gate bit clear resumes peripheral, state kept
// - gating acts in active, idle; else stopped
// - enabled converter stays enabled during sleep
// - first conversion after re-enable is extended
// - comparator auto-off except idle, noise reduction
// - comparator using reference keeps reference on
// - fuse-enabled brownout detector stays on asleep
// - reference on when detector, comparator, converter need
`ifndef SPC_MAP_VH
`define SPC_MAP_VH
// register offsets
`define SPC_A_DIV 8'h00
`define SPC_A_SLP 8'h01
`define SPC_A_GATE 8'h02
`define SPC_A_ANA 8'h03
`define SPC_A_STAT 8'h04
// address bit that selects the peripheral window
`define SPC_A_PER_BIT 7
// field positions
`define SPC_SLP_EN_BIT 0
`define SPC_ANA_ADC_BIT 0
`define SPC_ANA_ACMP_BIT 1
`define SPC_ANA_BG_BIT 2
// reset values
`define SPC_DIV_RST 4'h0
`define SPC_GATE_RST 8'h00
// highest legal divider select code
`define SPC_DIV_MAX 4'h8
// sleep mode codes
`define SPC_SM_IDLE 3'h0
`define SPC_SM_ADCNR 3'h1
`define SPC_SM_PDOWN 3'h2
`define SPC_SM_PSAVE 3'h3
`define SPC_SM_STBY 3'h6
`define SPC_SM_XSTBY 3'h7
// wake counts in clock cycles
`define SPC_WAKE_STBY 8'h06
`define SPC_WAKE_FAST 8'h01
`define SPC_WAKE_OSC 8'h10
// brownout fuse code that means detector off
`define SPC_BOD_OFF 3'h7
`endif

// [design/spc_sync.v]
// two-flip-flop synchroniser for levels that arrive from pins
`timescale 1ns/1ns
`default_nettype none
module spc_sync #(
  parameter W = 1
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // level from outside the clock domain
  input wire [W-1:0] d_i,
  // synchronised level
  output reg [W-1:0] q_o
);
  // first stage, read only by the second stage
  reg [W-1:0] meta_reg;

  // plain double flop; reset to zero
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta_reg <= {W{1'b0}};
      q_o <= {W{1'b0}};
    end
    else
    begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule // spc_sync
`default_nettype wire

// [design/spc_clk_div.v]
// power-of-two clock prescaler giving a one-cycle enable pulse
`timescale 1ns/1ns
`default_nettype none
module spc_clk_div #(
  parameter W = 8
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // divide by two to the power of sel_i
  input wire [3:0] sel_i,
  // one-cycle enable at the divided rate
  output wire tick_o
);
  // free-running count
  reg [W-1:0] cnt_reg;
  // low bits that must all be ones for a tick
  wire [W-1:0] one_w = {{(W-1){1'b0}}, 1'b1};
  wire [W-1:0] mask_w = (one_w << sel_i) - one_w;

  // a select change takes effect at once; the first period may be short
  assign tick_o = ((cnt_reg & mask_w) == mask_w);

  // counter runs always so the select can change freely
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      cnt_reg <= {W{1'b0}};
    else
      cnt_reg <= cnt_reg + one_w;
  end
endmodule // spc_clk_div
`default_nettype wire

// [design/spc_top.v]
// sleep, prescaler, peripheral clock gating and analog power control
//
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "spc_map.vh"
module spc_top #(
  parameter N_PER = 8,
  parameter [7:0] WAKE_OSC = `SPC_WAKE_OSC
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // register port
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  // cpu side
  input wire sleep_cmd_i,
  output reg cpu_run_o,
  output reg cpu_clk_en_o,
  // pins and fuses from outside
  input wire wake_i,
  input wire ext_xtal_i,
  input wire [2:0] brownout_level_fuses_i,
  // oscillator control
  output reg osc_run_o,
  // gated peripherals
  input wire [8*N_PER-1:0] per_rdata_i,
  output reg [N_PER-1:0] per_clk_en_o,
  output reg [N_PER-1:0] per_wr_o,
  output reg [N_PER-1:0] per_rd_o,
  output reg [3:0] per_addr_o,
  output reg [7:0] per_wdata_o,
  // analog enables
  input wire adc_conv_done_i,
  output reg adc_en_o,
  output reg adc_ext_conv_o,
  output reg acmp_en_o,
  output reg ref_en_o,
  output reg brownout_detector_en_o
);
  // sleep states, one-hot
  localparam [2:0] ST_RUN = 3'b001;
  localparam [2:0] ST_SLEEP = 3'b010;
  localparam [2:0] ST_WAKE = 3'b100;

  // software registers
  reg [3:0] clk_div_sel_reg; // prescaler select
  reg [2:0] sleep_mode_sel_reg; // sleep mode code
  reg sleep_en_reg; // sleep instruction allowed
  reg [N_PER-1:0] periph_clock_gate_reg; // one bit per peripheral
  reg adc_on_reg; // converter enable
  reg acmp_on_reg; // comparator enable
  reg comparator_bandgap_sel_reg; // comparator uses reference

  // sleep sequencer
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [7:0] wake_cnt_reg;
  reg [7:0] wake_cnt_next;
  reg [2:0] mode_reg; // mode latched at sleep entry
  reg [2:0] mode_next;

  // synchronised pin levels
  wire wake_s;
  wire xtal_s;
  wire [2:0] fuse_s;

  // prescaler pulse
  wire div_tick;

  // bus decode
  wire per_hit = addr_i[`SPC_A_PER_BIT];
  wire [2:0] per_idx = addr_i[6:4];
  wire [N_PER-1:0] per_sel;
  wire [N_PER-1:0] per_live;
  reg [7:0] per_rd_mux;
  reg [7:0] rd_next;
  integer k;

  // derived sleep conditions
  wire asleep = ~state_reg[0];
  wire mode_idle = (mode_reg == `SPC_SM_IDLE);
  wire mode_adcnr = (mode_reg == `SPC_SM_ADCNR);
  // standby only counts with a crystal clock; otherwise it acts as power-down
  wire mode_stby = (mode_reg == `SPC_SM_STBY) & xtal_s;
  wire mode_xstby = (mode_reg == `SPC_SM_XSTBY);
  // peripheral clocks may run only in active or idle
  wire per_clk_ok = ~asleep | mode_idle;
  wire bod_on = (fuse_s != `SPC_BOD_OFF);
  // legal sleep mode codes; the two unused codes are refused
  wire mode_ok = (sleep_mode_sel_reg != 3'h4) & (sleep_mode_sel_reg != 3'h5);

  // pin synchronisers
  spc_sync #(
    .W(5)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({wake_i, ext_xtal_i, brownout_level_fuses_i}),
    .q_o({wake_s, xtal_s, fuse_s})
  );

  // system clock prescaler
  spc_clk_div #(
    .W(8)
  ) u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sel_i(clk_div_sel_reg),
    .tick_o(div_tick)
  );

  // per-peripheral select and liveness
  genvar g;
  generate
    for (g = 0; g < N_PER; g = g + 1)
    begin : g_per
      // addressed when the window bit is set and the index matches
      assign per_sel[g] = per_hit & (per_idx == g);
      // registers reachable only while the clock is not gated
      assign per_live[g] = ~periph_clock_gate_reg[g];
    end
  endgenerate

  // software register writes
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      clk_div_sel_reg <= `SPC_DIV_RST;
      sleep_mode_sel_reg <= `SPC_SM_IDLE;
      sleep_en_reg <= 1'b0;
      periph_clock_gate_reg <= {N_PER{1'b0}};
      adc_on_reg <= 1'b0;
      acmp_on_reg <= 1'b0;
      comparator_bandgap_sel_reg <= 1'b0;
    end
    else if (wr_i)
    begin
      case (addr_i)
        `SPC_A_DIV:
        begin
          // reserved codes have no division; such a write is dropped
          if (wdata_i[3:0] <= `SPC_DIV_MAX)
            clk_div_sel_reg <= wdata_i[3:0];
        end
        `SPC_A_SLP:
        begin
          sleep_en_reg <= wdata_i[`SPC_SLP_EN_BIT];
          sleep_mode_sel_reg <= wdata_i[3:1];
        end
        `SPC_A_GATE:
          periph_clock_gate_reg <= wdata_i[N_PER-1:0];
        `SPC_A_ANA:
        begin
          adc_on_reg <= wdata_i[`SPC_ANA_ADC_BIT];
          acmp_on_reg <= wdata_i[`SPC_ANA_ACMP_BIT];
          comparator_bandgap_sel_reg <= wdata_i[`SPC_ANA_BG_BIT];
        end
        default:
        begin
          // other addresses hold no control state
        end
      endcase
    end
  end

  // sleep sequencer next state
  always @*
  begin
    state_next = state_reg;
    wake_cnt_next = wake_cnt_reg;
    mode_next = mode_reg;
    case (state_reg)
      ST_RUN:
      begin
        // sleep instruction is a nop unless enabled with a legal mode
        if (sleep_cmd_i & sleep_en_reg & mode_ok)
        begin
          state_next = ST_SLEEP;
          mode_next = sleep_mode_sel_reg;
        end
      end
      ST_SLEEP:
      begin
        if (wake_s)
        begin
          state_next = ST_WAKE;
          // oscillator kept running means a short fixed wake
          if (mode_stby | mode_xstby)
            wake_cnt_next = `SPC_WAKE_STBY;
          else if (mode_idle | mode_adcnr)
            wake_cnt_next = `SPC_WAKE_FAST;
          else
            wake_cnt_next = WAKE_OSC;
        end
      end
      ST_WAKE:
      begin
        // count down; the core runs again when the count expires
        wake_cnt_next = wake_cnt_reg - 8'h01;
        if (wake_cnt_reg == 8'h01)
          state_next = ST_RUN;
      end
      default:
        state_next = ST_RUN;
    endcase
  end

  // sleep sequencer registers
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg <= ST_RUN;
      wake_cnt_reg <= 8'h00;
      mode_reg <= `SPC_SM_IDLE;
    end
    else
    begin
      state_reg <= state_next;
      wake_cnt_reg <= wake_cnt_next;
      mode_reg <= mode_next;
    end
  end

  // core and oscillator controls
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cpu_run_o <= 1'b1;
      cpu_clk_en_o <= 1'b0;
      osc_run_o <= 1'b1;
    end
    else
    begin
      cpu_run_o <= state_next[0];
      // core clock pulses at the prescaled rate only while running
      cpu_clk_en_o <= div_tick & state_reg[0];
      // standby with a crystal keeps the oscillator; power-down, power-save and crystal-less standby stop it
      if (state_next == ST_SLEEP)
        osc_run_o <= mode_ok & (mode_next != `SPC_SM_PDOWN) & (mode_next != `SPC_SM_PSAVE)
          & ((mode_next != `SPC_SM_STBY) | xtal_s);
      else
        osc_run_o <= 1'b1;
    end
  end

  // peripheral clocks: prescaled, gated per bit and by sleep mode
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      per_clk_en_o <= {N_PER{1'b0}};
    else
      per_clk_en_o <= {N_PER{div_tick & per_clk_ok}} & ~periph_clock_gate_reg;
  end

  // peripheral strobes, one cycle behind the bus, suppressed when gated
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      per_wr_o <= {N_PER{1'b0}};
      per_rd_o <= {N_PER{1'b0}};
      per_addr_o <= 4'h0;
      per_wdata_o <= 8'h00;
    end
    else
    begin
      per_wr_o <= {N_PER{wr_i}} & per_sel & per_live;
      per_rd_o <= {N_PER{rd_i}} & per_sel & per_live;
      per_addr_o <= addr_i[3:0];
      per_wdata_o <= wdata_i;
    end
  end

  // peripheral read data, zero when the addressed one is gated
  always @*
  begin
    per_rd_mux = 8'h00;
    for (k = 0; k < N_PER; k = k + 1)
    begin
      if (per_sel[k] & per_live[k])
        per_rd_mux = per_rdata_i[8*k +: 8];
    end
  end

  // read data selection
  always @*
  begin
    rd_next = 8'h00;
    if (per_hit)
      rd_next = per_rd_mux;
    else
    begin
      case (addr_i)
        `SPC_A_DIV:
          rd_next = {4'h0, clk_div_sel_reg};
        `SPC_A_SLP:
          rd_next = {4'h0, sleep_mode_sel_reg, sleep_en_reg};
        `SPC_A_GATE:
          rd_next[N_PER-1:0] = periph_clock_gate_reg;
        `SPC_A_ANA:
          rd_next = {5'h00, comparator_bandgap_sel_reg, acmp_on_reg, adc_on_reg};
        `SPC_A_STAT:
          rd_next = {2'h0, brownout_detector_en_o, ref_en_o, acmp_en_o, adc_ext_conv_o, osc_run_o, asleep};
        default:
          rd_next = 8'h00;
      endcase
    end
  end

  // read data stands for the single cycle after the strobe
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_o <= 8'h00;
    else if (rd_i)
      rdata_o <= rd_next;
    else
      rdata_o <= 8'h00;
  end

  // analog enables and reference demand
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      adc_en_o <= 1'b0;
      acmp_en_o <= 1'b0;
      ref_en_o <= 1'b0;
      brownout_detector_en_o <= 1'b0;
    end
    else
    begin
      // converter follows software only, sleep does not touch it
      adc_en_o <= adc_on_reg;
      // comparator is forced off outside idle and noise reduction
      acmp_en_o <= acmp_on_reg & (~asleep | mode_idle | mode_adcnr);
      // detector follows the fuses whatever the sleep state
      brownout_detector_en_o <= bod_on;
      // a comparator wired to the reference holds it on even asleep
      ref_en_o <= bod_on | (acmp_on_reg & comparator_bandgap_sel_reg) | adc_on_reg;
    end
  end

  // extended conversion flag: set on re-enable, cleared by a finished conversion
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      adc_ext_conv_o <= 1'b0;
    else if (wr_i & ~per_hit & (addr_i == `SPC_A_ANA) & wdata_i[`SPC_ANA_ADC_BIT] & ~adc_on_reg)
      adc_ext_conv_o <= 1'b1;
    else if (adc_conv_done_i | ~adc_on_reg)
      adc_ext_conv_o <= 1'b0;
  end
endmodule // spc_top
`default_nettype wire

// [sim/spc_top_monitor.sv]
// assertion checker bound to the sleep clock power block
`timescale 1ns/1ns
`default_nettype none
module spc_top_monitor #(
  parameter N_PER = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  // core and pins
  input wire logic sleep_cmd_i,
  input wire logic cpu_run_o,
  input wire logic wake_i,
  input wire logic ext_xtal_i,
  input wire logic [2:0] brownout_level_fuses_i,
  input wire logic osc_run_o,
  // peripherals
  input wire logic [N_PER-1:0] per_clk_en_o,
  input wire logic [N_PER-1:0] per_wr_o,
  input wire logic [N_PER-1:0] per_rd_o,
  input wire logic [7:0] per_wdata_o,
  // analog
  input wire logic adc_conv_done_i,
  input wire logic adc_en_o,
  input wire logic adc_ext_conv_o,
  input wire logic acmp_en_o,
  input wire logic ref_en_o,
  input wire logic brownout_detector_en_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // shadows of the control registers, updated on the write edge
  logic [7:0] gate_q, ana_q, slp_q;
  logic [2:0] mode_q;
  // need history; synchronised fuses take three edges to show
  logic [1:0] nd1, nd2, nd3;
  logic [3:0] up;
  wire [2:0] idx = addr_i[6:4];
  wire win = addr_i[7] && (idx < N_PER);
  wire brownout_detector = brownout_level_fuses_i != 3'h7;
  wire [1:0] need = {brownout_detector, brownout_detector | ana_q[0] | (ana_q[1] & ana_q[2])};
  // shadow registers and settle history
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      gate_q <= 8'h00;
      ana_q <= 8'h00;
      slp_q <= 8'h00;
      mode_q <= 3'h0;
      up <= 4'h0;
    end
    else
    begin
      if (wr_i && addr_i == 8'h02)
        gate_q <= wdata_i;
      if (wr_i && addr_i == 8'h03)
        ana_q <= wdata_i;
      if (wr_i && addr_i == 8'h01)
        slp_q <= wdata_i;
      // mode is latched when the core goes to sleep
      if (sleep_cmd_i && cpu_run_o)
        mode_q <= slp_q[3:1];
      up <= {up[2:0], 1'b1};
    end
  always_ff @(posedge clk_i)
  begin
    nd1 <= need;
    nd2 <= nd1;
    nd3 <= nd2;
  end
  chk_gated_access: assert property ((rd_i || wr_i) && win && gate_q[idx] |=> !per_wr_o && !per_rd_o && !rdata_o)
    else $error("gated peripheral was accessed");
  chk_open_write: assert property (wr_i && win && !gate_q[idx] |=> per_wr_o[$past(idx)] && per_wdata_o == $past(wdata_i))
    else $error("open peripheral write lost");
  chk_gated_clock: assert property ((per_clk_en_o & gate_q[N_PER-1:0] & $past(gate_q[N_PER-1:0])) == '0)
    else $error("gated peripheral clock ran");
  chk_standby_osc: assert property (sleep_cmd_i && cpu_run_o && slp_q[0] && slp_q[3:1] == 3'h6 && ext_xtal_i
    |=> !cpu_run_o && osc_run_o)
    else $error("standby entry wrong");
  chk_pdown_osc: assert property (sleep_cmd_i && cpu_run_o && slp_q[0] && slp_q[3:1] == 3'h2 |=> !cpu_run_o && !osc_run_o)
    else $error("power-down kept oscillator");
  // pin edge seen one edge late, two synchroniser edges, the taking edge, then six counted edges
  chk_standby_wake: assert property (!cpu_run_o && osc_run_o && mode_q == 3'h6 && $rose(wake_i)
    |-> !cpu_run_o [*8] ##1 !cpu_run_o ##1 cpu_run_o)
    else $error("standby wake time wrong");
  chk_adc_follow: assert property (adc_en_o == $past(ana_q[0]))
    else $error("converter enable lost");
  chk_acmp_asleep: assert property (!cpu_run_o && $past(!cpu_run_o) && mode_q > 3'h1 |-> !acmp_en_o)
    else $error("comparator on in deep sleep");
  chk_ext_set: assert property (wr_i && addr_i == 8'h03 && wdata_i[0] && !ana_q[0] |=> adc_ext_conv_o)
    else $error("extended conversion not flagged");
  chk_ext_done: assert property (adc_conv_done_i && adc_ext_conv_o && !wr_i |=> !adc_ext_conv_o)
    else $error("extended flag not cleared");
  chk_ref_need: assert property (up[3] && nd1 == nd2 && nd2 == nd3 |-> {brownout_detector_en_o, ref_en_o} == nd1)
    else $error("reference or detector enable wrong");
endmodule // spc_top_monitor
bind spc_top spc_top_monitor #(.N_PER(N_PER)) u_mon (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sleep_cmd_i(sleep_cmd_i), .cpu_run_o(cpu_run_o),
  .wake_i(wake_i), .ext_xtal_i(ext_xtal_i), .brownout_level_fuses_i(brownout_level_fuses_i), .osc_run_o(osc_run_o),
  .per_clk_en_o(per_clk_en_o), .per_wr_o(per_wr_o), .per_rd_o(per_rd_o), .per_wdata_o(per_wdata_o),
  .adc_conv_done_i(adc_conv_done_i), .adc_en_o(adc_en_o), .adc_ext_conv_o(adc_ext_conv_o),
  .acmp_en_o(acmp_en_o), .ref_en_o(ref_en_o), .brownout_detector_en_o(brownout_detector_en_o));
`default_nettype wire

// [sim/spc_periph_model.sv]
// behavioural model of the gated peripherals
`timescale 1ns/1ns
`default_nettype none
module spc_periph_model #(
  parameter N_PER = 2
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // strobes and clocks from the block
  input wire logic [N_PER-1:0] per_clk_en_i,
  input wire logic [N_PER-1:0] per_wr_i,
  input wire logic [3:0] per_addr_i,
  input wire logic [7:0] per_wdata_i,
  // read address straight from the bus
  input wire logic [3:0] addr_i,
  output logic [8*N_PER-1:0] per_rdata_o
);
  // data register, bit 0 lets the counter run
  logic [7:0] data_q [N_PER];
  logic [7:0] cnt_q [N_PER];
  // counter only moves on its own clock, so a gated one stays frozen
  always @(posedge clk_i or posedge rst_i)
    for (int i = 0; i < N_PER; i++)
      if (rst_i)
      begin
        data_q[i] <= 8'h00;
        cnt_q[i] <= 8'h00;
      end
      else
      begin
        if (per_wr_i[i] && per_addr_i == 4'h0)
          data_q[i] <= per_wdata_i;
        if (per_clk_en_i[i] && data_q[i][0])
          cnt_q[i] <= cnt_q[i] + 8'h01;
      end
  // read mux: 0 data, 1 counter, others zero
  always_comb
    for (int i = 0; i < N_PER; i++)
      per_rdata_o[8*i +: 8] = (addr_i == 4'h0) ? data_q[i] : (addr_i == 4'h1) ? cnt_q[i] : 8'h00;
endmodule // spc_periph_model
`default_nettype wire

// [sim/test_spc_top.sv]
// self-checking bench for the sleep clock power block
`timescale 1ns/1ns
`default_nettype none
module test_spc_top;
  logic clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, sleep_cmd_i = 1'b0, wake_i = 1'b0;
  logic ext_xtal_i = 1'b1, adc_conv_done_i = 1'b0;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, per_wdata_o;
  logic [2:0] brownout_level_fuses_i = 3'h4;
  logic cpu_run_o, cpu_clk_en_o, osc_run_o, adc_en_o, adc_ext_conv_o, acmp_en_o, ref_en_o, brownout_detector_en_o;
  logic [15:0] per_rdata_i;
  logic [1:0] per_clk_en_o, per_wr_o, per_rd_o;
  logic [3:0] per_addr_o;
  int bad_count = 0, check_count = 0, n, p;
  // sleep rows: mode, analog bits, osc, peripheral clock, comparator, wake edges
  // wake edges: two synchroniser edges, the taking edge, then the mode's wake count
  int row [5][6] = '{'{0, 7, 1, 1, 1, 3 + 1}, '{1, 6, 1, 0, 1, 3 + 1}, '{2, 6, 0, 0, 0, 3 + 2},
    '{6, 6, 1, 0, 0, 3 + 6}, '{7, 6, 1, 0, 0, 3 + 6}};
  spc_top #(.N_PER(2), .WAKE_OSC(8'h02)) DUT (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sleep_cmd_i(sleep_cmd_i), .cpu_run_o(cpu_run_o),
    .cpu_clk_en_o(cpu_clk_en_o), .wake_i(wake_i), .ext_xtal_i(ext_xtal_i),
    .brownout_level_fuses_i(brownout_level_fuses_i), .osc_run_o(osc_run_o), .per_rdata_i(per_rdata_i),
    .per_clk_en_o(per_clk_en_o), .per_wr_o(per_wr_o), .per_rd_o(per_rd_o), .per_addr_o(per_addr_o),
    .per_wdata_o(per_wdata_o), .adc_conv_done_i(adc_conv_done_i), .adc_en_o(adc_en_o),
    .adc_ext_conv_o(adc_ext_conv_o), .acmp_en_o(acmp_en_o), .ref_en_o(ref_en_o),
    .brownout_detector_en_o(brownout_detector_en_o));
  spc_periph_model #(.N_PER(2)) u_per (.clk_i(clk_i), .rst_i(rst_i), .per_clk_en_i(per_clk_en_o),
    .per_wr_i(per_wr_o), .per_addr_i(per_addr_o), .per_wdata_i(per_wdata_o), .addr_i(addr_i[3:0]),
    .per_rdata_o(per_rdata_i));
  initial forever #20 clk_i = ~clk_i;
  // verdict and end of run
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one write, then an idle cycle so strobes never merge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 check(what, rdata_o, exp);
    @(posedge clk_i);
  endtask
  // edges until the core runs again, bounded
  task automatic wait_run(output int c);
    c = 0;
    while (cpu_run_o !== 1'b1)
    begin
      @(posedge clk_i);
      #1 c++;
      if (c > 300)
      begin
        bad_count++;
        stop_test();
      end
    end
    @(posedge clk_i);
  endtask
  // edges between two core clock pulses, bounded; the first period after a select change may be short
  task automatic period(output int c);
    for (int k = 0; k < 2; k++)
    begin
      c = 0;
      do
        @(posedge clk_i) #1 c++;
      while (cpu_clk_en_o !== 1'b1 && c < 600);
    end
    if (c >= 600)
    begin
      bad_count++;
      stop_test();
    end
    @(posedge clk_i);
  endtask
  initial
  begin
    #3000000;
    bad_count++;
    stop_test();
  end
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    check("detector", brownout_detector_en_o, 1);
    check("reference", ref_en_o, 1);
    wr(8'h10, 8'h5a);
    rd(8'h10, 8'h00, "unmapped");
    for (n = 5; n < 9; n++)
    begin
      wr(8'h00, n[7:0]);
      period(p);
      check("divide", p, 1 << n);
    end
    wr(8'h00, 8'h09);
    rd(8'h00, 8'h08, "reserved divide");
    wr(8'h00, 8'h00);
    // peripheral stopped, gated, touched, then released
    wr(8'h80, 8'ha4);
    wr(8'h02, 8'h01);
    rd(8'h80, 8'h00, "gated read");
    wr(8'h80, 8'hff);
    p = 0;
    repeat (40) @(posedge clk_i) #1 p += per_clk_en_o[0] + 2 * per_clk_en_o[1];
    check("gated clock", p > 0 && p % 2 == 0, 1);
    @(posedge clk_i);
    wr(8'h02, 8'h00);
    rd(8'h80, 8'ha4, "state kept");
    // extended conversion after each re-enable
    for (n = 0; n < 2; n++)
    begin
      wr(8'h03, 8'h00);
      wr(8'h03, 8'h01);
      check("ext conv", adc_ext_conv_o, 1);
      adc_conv_done_i <= 1'b1;
      @(posedge clk_i);
      adc_conv_done_i <= 1'b0;
      @(posedge clk_i) #1 check("ext clear", adc_ext_conv_o, 0);
      @(posedge clk_i);
    end
    brownout_level_fuses_i <= 3'h7;
    wr(8'h03, 8'h00);
    repeat (4) @(posedge clk_i);
    check("reference off", {brownout_detector_en_o, ref_en_o}, 0);
    rd(8'h04, 8'h02, "status");
    // idle, noise reduction, power-down, standby and extended standby
    for (n = 0; n < 5; n++)
    begin
      wr(8'h03, row[n][1][7:0]);
      wr(8'h01, {4'h0, row[n][0][2:0], 1'b1});
      sleep_cmd_i <= 1'b1;
      @(posedge clk_i);
      sleep_cmd_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      #1 check("asleep", cpu_run_o, 0);
      check("osc", osc_run_o, row[n][2]);
      check("comparator", acmp_en_o, row[n][4]);
      check("converter", adc_en_o, row[n][1] % 2);
      check("reference", ref_en_o, 1);
      p = 0;
      repeat (20) @(posedge clk_i) #1 p += per_clk_en_o[1];
      check("sleep clock", p > 0, row[n][3]);
      @(posedge clk_i);
      wake_i <= 1'b1;
      wait_run(p);
      check("wake", p, row[n][5]);
      wake_i <= 1'b0;
      @(posedge clk_i);
    end
    stop_test();
  end
endmodule // test_spc_top
`default_nettype wire
